// file: psr_consts.svh
/*
  constants of the parameter save/restore command block: register offsets,
  command keys, the done value, subindex codes, category mask bits and table layout.
  assumes inclusion by bare name from the package and the design files.
*/
`ifndef PSR_CONSTS_SVH
`define PSR_CONSTS_SVH

// ************************************************************
// register offsets (byte addresses on the apb bus)
// ************************************************************
`define PSR_OFS_SAVE_SEL   12'h000
`define PSR_OFS_SAVE_VAL   12'h004
`define PSR_OFS_DISC_SEL   12'h008
`define PSR_OFS_DISC_VAL   12'h00C
`define PSR_OFS_BOOT_VAL   12'h010
`define PSR_OFS_STATUS     12'h014
`define PSR_OFS_STORED     12'h018

// ************************************************************
// command keys
// ************************************************************
`define PSR_KEY_SAVE       32'h65766173
`define PSR_KEY_DISCARD    32'h64616F6C
`define PSR_KEY_REBOOT     32'h746F6F62
`define PSR_DONE_VAL       32'h00000001

// ************************************************************
// subindex codes
// ************************************************************
`define PSR_SUB_ALL        8'h01
`define PSR_SUB_COMM       8'h02
`define PSR_SUB_APPL       8'h03
`define PSR_SUB_CUST       8'h04
`define PSR_SUB_DRIVE      8'h05
`define PSR_SUB_TUNE       8'h06
`define PSR_SUB_ETH        8'h0C

// ************************************************************
// category mask bits and layout
// ************************************************************
`define PSR_CAT_COMM       6'h01
`define PSR_CAT_APPL       6'h02
`define PSR_CAT_CUST       6'h04
`define PSR_CAT_DRIVE      6'h08
`define PSR_CAT_TUNE       6'h10
`define PSR_CAT_ETH        6'h20
`define PSR_CAT_NONE       6'h00
`define PSR_SLOTS          8
`define PSR_STEP_CYC       16

`endif

// file: psr_ctrl.sv
/*
  parameter save/restore command block: apb register file for the save,
  discard and reboot command values, key checks, category mapping, and a
  restart request. assumes the medium handshakes on mem_req/mem_ack and
  the system restarts on restart_req.
*/
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "psr_consts.svh"

// Function
// - save key on subindex persists category
// - finished save overwrites value with 1
// - save subindex to category mapping
// - discard key erases mapped category
// - discard mapping equals save mapping
// - discard leaves live values until restart
// - reboot key on subindex 01 restarts
// - factory reset keeps tuning category
// - tuning erased only via subindex 06
// - factory reset keeps ethernet category
// - only whole categories are persisted
module psr_ctrl
  import psr_pkg::*;
#(
  parameter int SLOTS = `PSR_SLOTS // depth of each command value table
)
(
  input wire logic pclk, // bus clock, 40 MHz
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic mem_req, // medium step request
  output logic mem_erase, // medium step erases
  output logic [5:0] mem_cat, // medium step category
  input wire logic mem_ack, // medium step done
  output logic restart_req // controller restart
);
  import psr_pkg::*;

  // ************************************************************
  // registers
  // ************************************************************
  logic [7:0] save_sel_r;
  logic [7:0] disc_sel_r;
  logic [31:0] save_val_r [SLOTS];
  logic [31:0] disc_val_r [SLOTS];
  logic [31:0] boot_val_r;
  logic [5:0] stored_r; // categories that hold persisted data
  logic restart_r;
  logic pend_erase_r;
  logic [2:0] pend_slot_r;
  psr_cat_t pend_cats_r;
  psr_job_s job;
  logic busy;
  logic done;
  logic wr_acc;
  logic rd_acc;
  logic addr_ok;
  logic cmd_idle;

  // the slot index is three bits wide, so the tables cannot be resized
  if (SLOTS != `PSR_SLOTS) begin : g_slots_check
    $error("psr_ctrl: SLOTS must equal the slot table depth");
  end

  // subindex to slot; 7 marks an unmapped subindex
  function automatic logic [2:0] sub_slot(input logic [7:0] sub);
    if (sub == `PSR_SUB_ALL) sub_slot = 3'h0;
    else if (sub == `PSR_SUB_COMM) sub_slot = 3'h1;
    else if (sub == `PSR_SUB_APPL) sub_slot = 3'h2;
    else if (sub == `PSR_SUB_CUST) sub_slot = 3'h3;
    else if (sub == `PSR_SUB_DRIVE) sub_slot = 3'h4;
    else if (sub == `PSR_SUB_TUNE) sub_slot = 3'h5;
    else if (sub == `PSR_SUB_ETH) sub_slot = 3'h6;
    else sub_slot = 3'h7;
  endfunction : sub_slot

  // slot to category mask, shared by save and discard
  function automatic psr_cat_t slot_cats(input logic [2:0] s);
    case (s)
      3'h0: slot_cats = `PSR_CAT_COMM | `PSR_CAT_APPL | `PSR_CAT_CUST
                        | `PSR_CAT_DRIVE;
      3'h1: slot_cats = `PSR_CAT_COMM;
      3'h2: slot_cats = `PSR_CAT_APPL;
      3'h3: slot_cats = `PSR_CAT_CUST;
      3'h4: slot_cats = `PSR_CAT_DRIVE;
      3'h5: slot_cats = `PSR_CAT_TUNE;
      3'h6: slot_cats = `PSR_CAT_ETH;
      default: slot_cats = `PSR_CAT_NONE;
    endcase
  endfunction : slot_cats

  // ************************************************************
  // apb slave: zero wait states, error on unmapped address
  // ************************************************************
  assign pready = 1'b1;
  assign addr_ok = (paddr == `PSR_OFS_SAVE_SEL) || (paddr == `PSR_OFS_SAVE_VAL)
                   || (paddr == `PSR_OFS_DISC_SEL) || (paddr == `PSR_OFS_DISC_VAL)
                   || (paddr == `PSR_OFS_BOOT_VAL) || (paddr == `PSR_OFS_STATUS)
                   || (paddr == `PSR_OFS_STORED);
  assign pslverr = psel && penable && !addr_ok;
  assign wr_acc = psel && penable && pwrite && addr_ok;
  assign rd_acc = psel && penable && !pwrite;

  // read data is registered at the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      if (paddr == `PSR_OFS_SAVE_SEL) prdata <= {24'h000000, save_sel_r};
      else if (paddr == `PSR_OFS_SAVE_VAL) prdata <= save_val_r[sub_slot(save_sel_r)];
      else if (paddr == `PSR_OFS_DISC_SEL) prdata <= {24'h000000, disc_sel_r};
      else if (paddr == `PSR_OFS_DISC_VAL) prdata <= disc_val_r[sub_slot(disc_sel_r)];
      else if (paddr == `PSR_OFS_BOOT_VAL) prdata <= boot_val_r;
      else if (paddr == `PSR_OFS_STATUS) prdata <= {30'h00000000, restart_r, busy};
      else if (paddr == `PSR_OFS_STORED) prdata <= {26'h0000000, stored_r};
      else prdata <= 32'h00000000;
    end
  end

  // subindex selectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      save_sel_r <= `PSR_SUB_ALL;
      disc_sel_r <= `PSR_SUB_ALL;
    end else if (wr_acc) begin
      if (paddr == `PSR_OFS_SAVE_SEL) save_sel_r <= pwdata[7:0];
      else if (paddr == `PSR_OFS_DISC_SEL) disc_sel_r <= pwdata[7:0];
    end
  end

  // ************************************************************
  // command values and job launch
  // ************************************************************
  // writes to an unmapped subindex are dropped; a keyed write while a job
  // runs or waits is stored but launches nothing, so commands never overlap
  // and the slot that gets the done value always belongs to the running job
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < SLOTS; i++) begin
        save_val_r[i] <= 32'h00000000;
        disc_val_r[i] <= 32'h00000000;
      end
      pend_cats_r <= `PSR_CAT_NONE;
      pend_erase_r <= 1'b0;
      pend_slot_r <= 3'h0;
    end else begin
      if (done && !pend_erase_r) begin
        save_val_r[pend_slot_r] <= `PSR_DONE_VAL;
      end
      if (wr_acc && paddr == `PSR_OFS_SAVE_VAL && sub_slot(save_sel_r) != 3'h7) begin
        save_val_r[sub_slot(save_sel_r)] <= pwdata;
        if (pwdata == `PSR_KEY_SAVE && cmd_idle) begin
          pend_cats_r <= slot_cats(sub_slot(save_sel_r));
          pend_erase_r <= 1'b0;
          pend_slot_r <= sub_slot(save_sel_r);
        end
      end
      if (wr_acc && paddr == `PSR_OFS_DISC_VAL && sub_slot(disc_sel_r) != 3'h7) begin
        disc_val_r[sub_slot(disc_sel_r)] <= pwdata;
        if (pwdata == `PSR_KEY_DISCARD && cmd_idle) begin
          pend_cats_r <= slot_cats(sub_slot(disc_sel_r));
          pend_erase_r <= 1'b1;
          pend_slot_r <= sub_slot(disc_sel_r);
        end
      end
      if (job.valid) begin
        pend_cats_r <= `PSR_CAT_NONE;
      end
    end
  end

  // a job is handed over one cycle after the keyed write
  assign cmd_idle = !busy && (pend_cats_r == `PSR_CAT_NONE);
  // one driver for the whole job word: valid, erase, categories, slot
  assign job = {(pend_cats_r != `PSR_CAT_NONE) && !busy, pend_erase_r, pend_cats_r,
                pend_slot_r};

  // persisted-category record; live parameters are not touched by a discard
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stored_r <= `PSR_CAT_NONE;
    end else if (mem_req && mem_ack) begin
      if (mem_erase) stored_r <= stored_r & ~mem_cat;
      else stored_r <= stored_r | mem_cat;
    end
  end

  // ************************************************************
  // reboot
  // ************************************************************
  // restart waits for an idle medium so a save is never cut short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_val_r <= 32'h00000000;
      restart_r <= 1'b0;
    end else begin
      if (wr_acc && paddr == `PSR_OFS_BOOT_VAL) begin
        boot_val_r <= pwdata;
        if (pwdata == `PSR_KEY_REBOOT) restart_r <= 1'b1;
      end
    end
  end
  assign restart_req = restart_r && !busy && (pend_cats_r == `PSR_CAT_NONE);

  psr_store_seq psr_store_seq_inst (
    .pclk(pclk),
    .presetn(presetn),
    .job(job),
    .busy(busy),
    .done(done),
    .mem_req_r(mem_req),
    .mem_erase_r(mem_erase),
    .mem_cat_r(mem_cat),
    .mem_ack(mem_ack)
  );

  // ************************************************************
  // assertions
  // ************************************************************
  a_factory_keeps_tune: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h0 |-> !job.cats[4])
    else $error("factory reset touches tuning");
  a_factory_keeps_eth: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h0 |-> !job.cats[5])
    else $error("factory reset touches ethernet");
  a_tune_erase_only: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.erase && job.cats[4] |-> job.slot == 3'h5)
    else $error("tuning erased from wrong subindex");
  a_save_key_starts: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `PSR_OFS_SAVE_VAL && pwdata == `PSR_KEY_SAVE
    && sub_slot(save_sel_r) != 3'h7 && cmd_idle |=> job.valid)
    else $error("save key did not start job");
  a_bad_key_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !busy && pend_cats_r == `PSR_CAT_NONE && wr_acc && paddr == `PSR_OFS_SAVE_VAL
    && pwdata != `PSR_KEY_SAVE |=> !job.valid)
    else $error("wrong key started job");
  a_done_writes_one: assert property (@(posedge pclk) disable iff (!presetn)
    done && !pend_erase_r && !(wr_acc && paddr == `PSR_OFS_SAVE_VAL)
    |=> save_val_r[$past(pend_slot_r)] == `PSR_DONE_VAL)
    else $error("save end not reported");
  a_one_cat_step: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req |-> $onehot(mem_cat) && (mem_cat & ~`PSR_CAT_NONE) != 6'h00)
    else $error("medium step not whole category");
  a_reboot_key: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `PSR_OFS_BOOT_VAL && pwdata == `PSR_KEY_REBOOT |=> restart_r)
    else $error("reboot key ignored");
  a_discard_live: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && mem_erase |-> !restart_req)
    else $error("restart during discard");

  // category maps of the job word; save and discard share one table, so a
  // wrong entry would show on both commands at once
  a_map_all: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h0
    |-> job.cats == (`PSR_CAT_COMM | `PSR_CAT_APPL | `PSR_CAT_CUST | `PSR_CAT_DRIVE))
    else $error("subindex 01 maps the wrong categories");

  a_map_comm: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h1 |-> job.cats == `PSR_CAT_COMM)
    else $error("subindex 02 not mapped to communication");

  a_map_tune: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h5 |-> job.cats == `PSR_CAT_TUNE)
    else $error("subindex 06 not mapped to tuning");

  a_map_eth: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.slot == 3'h6 |-> job.cats == `PSR_CAT_ETH)
    else $error("subindex 0C not mapped to ethernet");

  // tuning and ethernet are reached only through their own subindex, which
  // keeps auto-setup results and network settings through a factory reset
  a_tune_save_only: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && !job.erase && job.cats[4] |-> job.slot == 3'h5)
    else $error("tuning saved from wrong subindex");

  a_eth_save_only: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && !job.erase && job.cats[5] |-> job.slot == 3'h6)
    else $error("ethernet saved from wrong subindex");

  a_eth_erase_only: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.erase && job.cats[5] |-> job.slot == 3'h6)
    else $error("ethernet erased from wrong subindex");

  // key handling: only the right key launches, and a read never does; a job
  // waiting for the sequencer is taken on the very next edge
  a_disc_key_starts: assert property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `PSR_OFS_DISC_VAL && pwdata == `PSR_KEY_DISCARD
    && sub_slot(disc_sel_r) != 3'h7 && cmd_idle |=> job.valid && job.erase)
    else $error("discard key did not start erase");

  a_bad_disc_idle: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_idle && wr_acc && paddr == `PSR_OFS_DISC_VAL && pwdata != `PSR_KEY_DISCARD
    |=> !job.valid)
    else $error("wrong discard key started job");

  a_read_no_launch: assert property (@(posedge pclk) disable iff (!presetn)
    cmd_idle && rd_acc |=> !job.valid)
    else $error("register read started job");

  a_handover: assert property (@(posedge pclk) disable iff (!presetn)
    job.valid |=> busy && pend_cats_r == `PSR_CAT_NONE)
    else $error("job not taken by the sequencer");

  // the stored record follows each finished step, and a restart waits for an
  // idle medium so no save is cut short
  a_persist_sets: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && mem_ack && !mem_erase
    |=> (stored_r & $past(mem_cat)) == $past(mem_cat))
    else $error("persisted category not recorded");

  a_erase_clears: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && mem_ack && mem_erase |=> (stored_r & $past(mem_cat)) == `PSR_CAT_NONE)
    else $error("erased category still recorded");

  a_step_holds: assert property (@(posedge pclk) disable iff (!presetn)
    mem_req && !mem_ack |=> mem_req && $stable(mem_cat))
    else $error("medium step dropped before its answer");

  a_restart_idle: assert property (@(posedge pclk) disable iff (!presetn)
    restart_req |-> !busy && !mem_req)
    else $error("restart while the medium is busy");

  a_restart_latch: assert property (@(posedge pclk) disable iff (!presetn)
    restart_r |=> restart_r)
    else $error("restart request dropped");

  // ************************************************************
  // covers
  // ************************************************************
  c_save_done: cover property (@(posedge pclk) disable iff (!presetn) done && !pend_erase_r);
  c_discard_done: cover property (@(posedge pclk) disable iff (!presetn) done && pend_erase_r);
  c_restart: cover property (@(posedge pclk) disable iff (!presetn) restart_req);
  c_factory_reset: cover property (@(posedge pclk) disable iff (!presetn)
    job.valid && job.erase && job.slot == 3'h0);
  c_bad_key: cover property (@(posedge pclk) disable iff (!presetn)
    wr_acc && paddr == `PSR_OFS_SAVE_VAL && pwdata != `PSR_KEY_SAVE);
endmodule : psr_ctrl

// file: psr_medium_model.sv
/*
  storage medium model: answers each category step after a short or long
  delay and keeps its own mask of persisted categories.
  assumes the psr_ctrl mem_req/mem_ack handshake on one clock.
*/
`timescale 1ns/1ps
module psr_medium_model (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic mem_req, // step request
  input wire logic mem_erase, // erase step
  input wire logic [5:0] mem_cat, // step category
  input wire logic slow, // stretch each step
  output logic mem_ack, // step done
  output logic [5:0] kept_r, // persisted mask
  output logic [7:0] steps_r, // steps seen
  output logic [7:0] bad_r // steps not one-hot
);
  logic [3:0] wait_r;

  // ack after one or nine cycles; the slow case shows nothing hurries the medium
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      mem_ack <= 1'b0;
    end else if (mem_req && !mem_ack) begin
      wait_r <= wait_r + 4'h1;
      mem_ack <= (wait_r >= (slow ? 4'h8 : 4'h0));
    end else begin
      wait_r <= 4'h0;
      mem_ack <= 1'b0;
    end
  end

  // log each finished step; only one whole category per step is legal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kept_r <= 6'h00;
      steps_r <= 8'h00;
      bad_r <= 8'h00;
    end else if (mem_req && mem_ack) begin
      steps_r <= steps_r + 8'h01;
      kept_r <= mem_erase ? (kept_r & ~mem_cat) : (kept_r | mem_cat);
      if ($countones(mem_cat) != 1) bad_r <= bad_r + 8'h01;
    end
  end
endmodule : psr_medium_model

// file: psr_pkg.sv
/*
  types of the parameter save/restore command block.
  assumes psr_consts.svh is on the include path.
*/
package psr_pkg;
  `include "psr_consts.svh"

  typedef logic [5:0] psr_cat_t;

  // one storage job handed to the storage sequencer
  typedef struct packed {
    logic valid;
    logic erase;
    psr_cat_t cats;
    logic [2:0] slot;
  } psr_job_s;

  typedef enum logic [1:0] {
    PSR_IDLE,
    PSR_BUSY,
    PSR_DONE
  } psr_state_e;
endpackage : psr_pkg

// file: psr_store_seq.sv
/*
  storage sequencer: walks one category at a time through the medium port,
  persisting or erasing, and reports a one-cycle done pulse.
  assumes the medium answers each category step with mem_ack.
*/
`timescale 1ns/1ps
module psr_store_seq
  import psr_pkg::*;
(
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire psr_pkg::psr_job_s job, // job request
  output logic busy, // job in progress
  output logic done, // one-cycle job end
  output logic mem_req_r, // medium request
  output logic mem_erase_r, // 1 erase, 0 persist
  output logic [5:0] mem_cat_r, // one-hot category
  input wire logic mem_ack // medium step done
);
  psr_state_e state_r;
  psr_cat_t left_r;
  logic erase_r;

  function automatic psr_cat_t low_bit(input psr_cat_t m);
    low_bit = m & (~m + 6'h01);
  endfunction : low_bit

  assign busy = (state_r != PSR_IDLE);

  // walk the category mask; whole categories only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= PSR_IDLE;
      left_r <= `PSR_CAT_NONE;
      erase_r <= 1'b0;
      mem_req_r <= 1'b0;
      mem_erase_r <= 1'b0;
      mem_cat_r <= `PSR_CAT_NONE;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_r)
        PSR_IDLE: begin
          if (job.valid && job.cats != `PSR_CAT_NONE) begin
            left_r <= job.cats;
            erase_r <= job.erase;
            state_r <= PSR_BUSY;
          end
        end
        PSR_BUSY: begin
          if (!mem_req_r) begin
            mem_req_r <= 1'b1;
            mem_erase_r <= erase_r;
            mem_cat_r <= low_bit(left_r);
          end else if (mem_ack) begin
            mem_req_r <= 1'b0;
            left_r <= left_r & ~mem_cat_r;
            if ((left_r & ~mem_cat_r) == `PSR_CAT_NONE) begin
              state_r <= PSR_DONE;
            end
          end
        end
        PSR_DONE: begin
          done <= 1'b1;
          state_r <= PSR_IDLE;
        end
        default: state_r <= PSR_IDLE;
      endcase
    end
  end
endmodule : psr_store_seq

// file: tb_top.sv
/*
  testbench of the save/discard/reboot command block over apb.
  assumes psr_ctrl with zero-wait apb and the medium model beside it.
*/
`timescale 1ns/1ps
`include "psr_consts.svh"
module tb_top;
  import psr_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, mem_req, mem_erase, mem_ack, restart_req;
  logic [5:0] mem_cat, kept;
  logic [7:0] steps, bad;
  logic slow = 1'b0;
  logic [31:0] q;
  logic e;
  int failures = 0;
  int checks_done = 0;
  int cyc = 0;

  always #12.5 pclk = ~pclk;

  psr_ctrl psr_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_erase(mem_erase), .mem_cat(mem_cat),
    .mem_ack(mem_ack), .restart_req(restart_req));
  psr_medium_model psr_medium_model_inst (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .mem_erase(mem_erase), .mem_cat(mem_cat), .slow(slow), .mem_ack(mem_ack),
    .kept_r(kept), .steps_r(steps), .bad_r(bad));

  // ************************************************************
  // checking and closing
  // ************************************************************
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // a hang counts as a failure and still reaches the report
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      failures++;
      give_verdict;
    end
  end

  // ************************************************************
  // apb master
  // ************************************************************
  // one idle cycle after each transfer keeps psel from two drives in one step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready is tied high, so this wait ends on the first access edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task rd(input logic [11:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task save(input logic [7:0] sub);
    int n;
    wr(`PSR_OFS_SAVE_SEL, {24'h0, sub}); // no motion is ever driven while saving
    wr(`PSR_OFS_SAVE_VAL, `PSR_KEY_SAVE);
    n = 0;
    do begin
      rd(`PSR_OFS_SAVE_VAL);
      n++;
    end while (q !== `PSR_DONE_VAL && n < 300);
    chk(q, `PSR_DONE_VAL);
  endtask : save

  task discard(input logic [7:0] sub);
    int n;
    wr(`PSR_OFS_DISC_SEL, {24'h0, sub});
    wr(`PSR_OFS_DISC_VAL, `PSR_KEY_DISCARD);
    repeat (3) @(posedge pclk);
    n = 0;
    do begin
      rd(`PSR_OFS_STATUS);
      n++;
    end while (q[0] !== 1'b0 && n < 300);
    rd(`PSR_OFS_DISC_VAL);
    chk(q, `PSR_KEY_DISCARD);
  endtask : discard

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset_and_badkey;
    rd(`PSR_OFS_SAVE_SEL);
    chk(q, 32'h00000001);
    rd(`PSR_OFS_STORED);
    chk(q, 32'h0);
    wr(`PSR_OFS_SAVE_SEL, 32'h00000002);
    wr(`PSR_OFS_SAVE_VAL, 32'h65766172);
    wr(`PSR_OFS_DISC_VAL, 32'h64616F6D);
    repeat (20) @(posedge pclk);
    chk({24'h0, steps}, 32'h0);
    rd(`PSR_OFS_STATUS);
    chk(q, 32'h0);
    $display("test reset_badkey done");
  endtask : t_reset_and_badkey

  // every subindex except 01 once, slow and fast medium alternating
  task t_save_each;
    logic [7:0] subs [6];
    subs = '{`PSR_SUB_COMM, `PSR_SUB_APPL, `PSR_SUB_CUST, `PSR_SUB_DRIVE, `PSR_SUB_TUNE,
      `PSR_SUB_ETH};
    for (int i = 0; i < 6; i++) begin
      slow <= i[0];
      save(subs[i]);
      rd(`PSR_OFS_STORED);
      chk(q, 32'h3F >> (5 - i));
      chk({26'h0, kept}, 32'h3F >> (5 - i));
    end
    slow <= 1'b0;
    $display("test save_each done");
  endtask : t_save_each

  task t_discard;
    discard(`PSR_SUB_ALL);
    chk({26'h0, kept}, 32'h30);
    chk({31'h0, restart_req}, 32'h0);
    discard(`PSR_SUB_TUNE);
    chk({26'h0, kept}, 32'h20);
    save(`PSR_SUB_ALL);
    // steps: six single saves, four factory erases, one tuning erase, four saves
    chk({24'h0, steps}, 32'h0F);
    rd(`PSR_OFS_STORED);
    chk(q, 32'h2F);
    chk({24'h0, bad}, 32'h0);
    $display("test discard done");
  endtask : t_discard

  task t_unmapped_and_reboot;
    rd(12'h0FC);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    chk(q, 32'h0);
    wr(`PSR_OFS_BOOT_VAL, 32'h746F6F63);
    repeat (5) @(posedge pclk);
    chk({31'h0, restart_req}, 32'h0);
    wr(`PSR_OFS_BOOT_VAL, `PSR_KEY_REBOOT);
    repeat (3) @(posedge pclk);
    chk({31'h0, restart_req}, 32'h1);
    rd(`PSR_OFS_STATUS);
    chk({31'h0, q[1]}, 32'h1);
    $display("test unmapped_reboot done");
  endtask : t_unmapped_and_reboot

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_and_badkey;
    t_save_each;
    t_discard;
    t_unmapped_and_reboot;
    give_verdict;
  end
endmodule : tb_top
